// File: src/twc_pkg.sv
package twc_pkg;
  // Register offsets, one byte each
  localparam logic [3:0] OFS_TIMING = 4'h0;
  localparam logic [3:0] OFS_DUAL = 4'h1;
  localparam logic [3:0] OFS_DBG = 4'h2;
  localparam logic [3:0] OFS_HCTLA = 4'h3;
  localparam logic [3:0] OFS_HCTLB = 4'h4;
  localparam logic [3:0] OFS_HSTAT = 4'h5;
  localparam logic [3:0] OFS_BAUD = 4'h6;
  localparam logic [3:0] OFS_HADDR = 4'h7;
  localparam logic [3:0] OFS_HDATA = 4'h8;
  localparam logic [3:0] OFS_CCTLA = 4'h9;
  localparam logic [3:0] OFS_CCTLB = 4'hA;
  localparam logic [3:0] OFS_CSTAT = 4'hB;
  localparam logic [3:0] OFS_CADDR = 4'hC;
  localparam logic [3:0] OFS_CDATA = 4'hD;
  localparam logic [3:0] OFS_CMASK = 4'hE;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bits
  localparam logic [7:0] TIMING_MASK = 8'h1E;
  localparam logic [7:0] DUAL_MASK = 8'h0F;
  localparam logic [7:0] DBG_MASK = 8'h01;
  localparam logic [7:0] HCTLA_MASK = 8'hDF;
  localparam logic [7:0] CCTLB_MASK = 8'h04;
  // Field positions
  localparam int SETUP_BIT = 4;
  localparam int HOLD_LSB = 2;
  localparam int FMP_BIT = 1;
  localparam int DUAL_EN_BIT = 0;
  localparam int RUN_BIT = 0;
  localparam int READ_IRQ_ENABLE_BIT = 7;
  localparam int WRITE_IRQ_ENABLE_BIT = 6;
  localparam int QUICK_COMMAND_ENABLE_BIT = 4;
  localparam int TOUT_LSB = 2;
  localparam int AUTO_ACK_ENABLE_BIT = 1;
  localparam int HEN_BIT = 0;
  localparam int FLUSH_BIT = 3;
  localparam int ACK_ACTION_BIT_BIT = 2;
  localparam int RIF_BIT = 7;
  localparam int WIF_BIT = 6;
  // Field codes
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_SHORT = 2'h1;
  localparam logic [1:0] HOLD_TYPICAL = 2'h2;
  localparam logic [1:0] HOLD_ALL = 2'h3;
  localparam logic [1:0] TOUT_OFF = 2'h0;
  localparam logic [1:0] TOUT_SHORTEST = 2'h1;
  localparam logic [1:0] TOUT_MIDDLE = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_OWNER = 2'h2;
  localparam logic [1:0] BUS_BUSY = 2'h3;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] SETUP_FOUR_CYC = 8'h04;
  localparam logic [7:0] SETUP_EIGHT_CYC = 8'h08;
  localparam int HOLD_SHORT_NS = 50;
  localparam int HOLD_TYPICAL_NS = 300;
  localparam int HOLD_ALL_NS = 500;
  localparam logic [7:0] HOLD_SHORT_CYC =
    8'((HOLD_SHORT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HOLD_TYPICAL_CYC =
    8'((HOLD_TYPICAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HOLD_ALL_CYC =
    8'((HOLD_ALL_NS * CLK_MHZ + 999) / 1000);
  localparam int TOUT_SHORTEST_US = 50;
  localparam int TOUT_MIDDLE_US = 100;
  localparam int TOUT_LONGEST_US = 200;

  typedef struct packed {
    logic addr_ack;
    logic addr_dir;
    logic rd_done;
    logic wr_done;
    logic client_bit;
  } twc_ev_s;

  typedef struct packed {
    logic valid;
    logic [1:0] code;
    logic ack_act;
    logic addr_go;
    logic tx_go;
    logic smart_ack;
    logic flush;
    logic cdata_go;
  } twc_cmd_s;

  typedef struct packed {
    logic host_en;
    logic quick;
    logic host_fmp;
    logic client_fmp;
    logic [1:0] host_hold;
    logic [1:0] client_hold;
    logic setup_long;
    logic dual_en;
    logic run;
  } twc_cfg_s;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_p;
    logic sda_p;
    logic [7:0] tim;
    logic [7:0] dual;
    logic [7:0] dbg;
    logic [7:0] hcta;
    logic ack_action_bit;
    logic read_done_flag;
    logic write_done_flag;
    logic [1:0] bus;
    logic [7:0] baud;
    logic [7:0] haddr;
    logic [7:0] hdata;
    logic [7:0] ccta;
    logic [7:0] cctb;
    logic [7:0] caddr;
    logic [7:0] cdata;
    logic [7:0] cmask;
    logic [7:0] rdata;
    logic [15:0] tcnt;
    twc_cmd_s cmd;
    twc_cfg_s cfg;
    logic rirq;
    logic wirq;
  } twc_state_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic busy;
  } twc_tmr_s;
endpackage

// File: src/twc_tmr.sv
`timescale 1ns/100ps
`default_nettype none
module twc_tmr (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire logic [7:0] load,
  // Stretch level
  output logic busy
);
  import twc_pkg::*;

  twc_tmr_s st_q;
  twc_tmr_s st_d;

  // Busy stands for exactly load cycles after start; zero gives none
  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.cnt = load - 8'h01;
      st_d.busy = (load != 8'h00);
    end else if (st_q.busy) begin
      if (st_q.cnt == 8'h00) begin
        st_d.busy = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
endmodule
`default_nettype wire

// File: src/twc_core.sv
// Operation
// - Outside a processor halt the unit runs normally.
// - A processor halt stops the unit unless run_while_halted is set.
// - Halted with run, data register access starts nothing, changes no flag.
// - Client SDA setup stretch is four cycles, or eight when selected.
// - Hold code selects off, short, typical SMBus or all-corner SMBus.
// - fast_plus_enable in timing control selects 1 MHz for unit or host.
// - Dual hold field sets client hold, ignored while dual mode is off.
// - Dual fast-plus bit sets client 1 MHz, ignored while dual is off.
// - Dual enable bit 0 splits host and client configuration.
// - Read interrupt needs read_irq_enable, global enable and read flag.
// - Write interrupt needs write_irq_enable, global enable and write flag.
// - Quick command sets read or write flag by direction, no data.
// - Nonzero time-out field forces bus state Idle after inactivity.
// - Time-out codes: off, 50, 100, 200 microseconds.
// - Halted without run, the unit stops and ignores events.
// - Auto-ack mode sends the held acknowledge when host data is read; the unit sends it only when the held bit is ACK, never a NACK.
// - Host enable bit enables the host; clear disables it.
`timescale 1ns/100ps
`default_nettype none
module twc_core #(
  parameter int TOUT_SHORTEST_CYC =
    twc_pkg::TOUT_SHORTEST_US * twc_pkg::CLK_MHZ,
  parameter int TOUT_MIDDLE_CYC = twc_pkg::TOUT_MIDDLE_US * twc_pkg::CLK_MHZ,
  parameter int TOUT_LONGEST_CYC = twc_pkg::TOUT_LONGEST_US * twc_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Processor state
  input wire logic DBG_HALT,
  input wire logic GIE,
  // Observed bus lines
  input wire logic SCL_PIN,
  input wire logic SDA_PIN,
  // Bus engine
  input wire twc_pkg::twc_ev_s EV,
  output twc_pkg::twc_cmd_s CMD,
  output twc_pkg::twc_cfg_s CFG,
  output logic [1:0] BUS_STATE,
  // Timing stretches
  output logic HOST_SDA_HOLD,
  output logic CLIENT_SDA_HOLD,
  output logic CLIENT_SCL_STRETCH,
  // Interrupt requests
  output logic RD_IRQ,
  output logic WR_IRQ
);
  import twc_pkg::*;

  twc_state_s st_q;
  twc_state_s st_d;
  // Pins idle high; a sync chain reset high sees no false edge on release
  localparam twc_state_s ST_RESET =
    {6'h3F, {($bits(twc_state_s) - 6){1'b0}}};
  logic run;
  logic data_ok;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic act;
  logic tout_hit;
  logic set_r;
  logic set_w;
  logic clr_f;
  logic setup_go;
  logic [15:0] lim;

  function automatic logic [7:0] hold_cyc(input logic [1:0] code);
    case (code)
      HOLD_SHORT: hold_cyc = HOLD_SHORT_CYC;
      HOLD_TYPICAL: hold_cyc = HOLD_TYPICAL_CYC;
      HOLD_ALL: hold_cyc = HOLD_ALL_CYC;
      default: hold_cyc = 8'h00;
    endcase
  endfunction

  function automatic logic [15:0] tout_lim(input logic [1:0] code);
    case (code)
      TOUT_SHORTEST: tout_lim = 16'(TOUT_SHORTEST_CYC);
      TOUT_MIDDLE: tout_lim = 16'(TOUT_MIDDLE_CYC);
      default: tout_lim = 16'(TOUT_LONGEST_CYC);
    endcase
  endfunction

  function automatic logic [7:0] rd_mux(input twc_state_s s,
                                        input logic [3:0] a);
    case (a)
      OFS_TIMING: rd_mux = s.tim;
      OFS_DUAL: rd_mux = s.dual;
      OFS_DBG: rd_mux = s.dbg;
      OFS_HCTLA: rd_mux = s.hcta;
      OFS_HCTLB: rd_mux = {5'h00, s.ack_action_bit, 2'h0};
      OFS_HSTAT: rd_mux = {s.read_done_flag, s.write_done_flag, 4'h0, s.bus};
      OFS_BAUD: rd_mux = s.baud;
      OFS_HADDR: rd_mux = s.haddr;
      OFS_HDATA: rd_mux = s.hdata;
      OFS_CCTLA: rd_mux = s.ccta;
      OFS_CCTLB: rd_mux = s.cctb;
      OFS_CADDR: rd_mux = s.caddr;
      OFS_CDATA: rd_mux = s.cdata;
      OFS_CMASK: rd_mux = s.cmask;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    // Second stage alone reads the first stage
    st_d.scl_sy = {st_q.scl_sy[0], SCL_PIN};
    st_d.sda_sy = {st_q.sda_sy[0], SDA_PIN};
    st_d.scl_p = st_q.scl_sy[1];
    st_d.sda_p = st_q.sda_sy[1];
    st_d.cmd = '0;
    run = !DBG_HALT || st_q.dbg[RUN_BIT];
    data_ok = !DBG_HALT;
    scl_fall = st_q.scl_p && !st_q.scl_sy[1];
    start_c = st_q.scl_p && st_q.scl_sy[1] && st_q.sda_p
              && !st_q.sda_sy[1];
    stop_c = st_q.scl_p && st_q.scl_sy[1] && !st_q.sda_p
             && st_q.sda_sy[1];
    act = (st_q.scl_p != st_q.scl_sy[1]) || (st_q.sda_p != st_q.sda_sy[1]);
    setup_go = run && EV.client_bit;
    lim = tout_lim(st_q.hcta[TOUT_LSB+:2]);
    // Register writes
    if (WR) begin
      case (ADDR)
        OFS_TIMING: st_d.tim = WDATA & TIMING_MASK;
        OFS_DUAL: st_d.dual = WDATA & DUAL_MASK;
        OFS_DBG: st_d.dbg = WDATA & DBG_MASK;
        OFS_HCTLA: st_d.hcta = WDATA & HCTLA_MASK;
        OFS_HCTLB: begin
          st_d.ack_action_bit = WDATA[ACK_ACTION_BIT_BIT];
          // Stop after a quick command arrives here as CMD_STOP
          st_d.cmd.valid = (WDATA[1:0] != CMD_NONE);
          st_d.cmd.code = WDATA[1:0];
          st_d.cmd.ack_act = WDATA[ACK_ACTION_BIT_BIT];
          st_d.cmd.flush = WDATA[FLUSH_BIT];
        end
        OFS_BAUD: st_d.baud = WDATA;
        OFS_HADDR: begin
          st_d.haddr = WDATA;
          st_d.cmd.addr_go = 1'b1;
        end
        OFS_HDATA: begin
          st_d.hdata = WDATA;
          st_d.cmd.tx_go = data_ok;
        end
        OFS_CCTLA: st_d.ccta = WDATA;
        OFS_CCTLB: st_d.cctb = WDATA & CCTLB_MASK;
        OFS_CADDR: st_d.caddr = WDATA;
        OFS_CDATA: begin
          st_d.cdata = WDATA;
          st_d.cmd.cdata_go = data_ok;
        end
        OFS_CMASK: st_d.cmask = WDATA;
        default: ;
      endcase
    end
    // Auto-ack only sends ACK; a held NACK is left to a command
    if (RD && ADDR == OFS_HDATA && data_ok && st_q.hcta[AUTO_ACK_ENABLE_BIT]
        && !st_q.ack_action_bit) begin
      st_d.cmd.smart_ack = 1'b1;
      st_d.cmd.ack_act = st_q.ack_action_bit;
    end
    st_d.rdata = RD ? rd_mux(st_q, ADDR) : 8'h00;
    // Host flags: a set in the clearing cycle wins
    set_r = run && (EV.rd_done || (EV.addr_ack && EV.addr_dir
            && st_q.hcta[QUICK_COMMAND_ENABLE_BIT]));
    set_w = run && (EV.wr_done || (EV.addr_ack && !EV.addr_dir));
    clr_f = (WR && ADDR == OFS_HADDR)
            || (data_ok && (WR || RD) && ADDR == OFS_HDATA)
            || (WR && ADDR == OFS_HCTLB && WDATA[1:0] != CMD_NONE);
    st_d.read_done_flag = set_r || (st_q.read_done_flag && !clr_f
               && !(WR && ADDR == OFS_HSTAT && WDATA[RIF_BIT]));
    st_d.write_done_flag = set_w || (st_q.write_done_flag && !clr_f
               && !(WR && ADDR == OFS_HSTAT && WDATA[WIF_BIT]));
    // Inactivity supervisor; counter frozen while the unit is halted
    tout_hit = 1'b0;
    if (!st_q.hcta[HEN_BIT] || st_q.hcta[TOUT_LSB+:2] == TOUT_OFF) begin
      st_d.tcnt = 16'h0000;
    end else if (run) begin
      if (act) begin
        st_d.tcnt = 16'h0000;
      end else if (st_q.tcnt != lim) begin
        st_d.tcnt = st_q.tcnt + 16'h0001;
        tout_hit = (st_q.tcnt == lim - 16'h0001);
      end
    end
    // Bus state
    if (!st_q.hcta[HEN_BIT]) begin
      st_d.bus = BUS_UNKNOWN;
    end else if (st_q.cmd.flush) begin
      st_d.bus = BUS_IDLE;
    end else if (run) begin
      if (start_c) begin
        st_d.bus = BUS_BUSY;
      end else if (stop_c || tout_hit) begin
        st_d.bus = BUS_IDLE;
      end else if (EV.addr_ack) begin
        st_d.bus = BUS_OWNER;
      end
    end
    // Effective configuration
    st_d.cfg.run = run;
    st_d.cfg.host_en = st_q.hcta[HEN_BIT];
    st_d.cfg.quick = st_q.hcta[QUICK_COMMAND_ENABLE_BIT];
    st_d.cfg.dual_en = st_q.dual[DUAL_EN_BIT];
    st_d.cfg.setup_long = st_q.tim[SETUP_BIT];
    st_d.cfg.host_fmp = st_q.tim[FMP_BIT];
    st_d.cfg.host_hold = st_q.tim[HOLD_LSB+:2];
    if (st_q.dual[DUAL_EN_BIT]) begin
      st_d.cfg.client_fmp = st_q.dual[FMP_BIT];
      st_d.cfg.client_hold = st_q.dual[HOLD_LSB+:2];
    end else begin
      st_d.cfg.client_fmp = st_q.tim[FMP_BIT];
      st_d.cfg.client_hold = st_q.tim[HOLD_LSB+:2];
    end
    st_d.rirq = st_q.read_done_flag && st_q.hcta[READ_IRQ_ENABLE_BIT] && GIE;
    st_d.wirq = st_q.write_done_flag && st_q.hcta[WRITE_IRQ_ENABLE_BIT] && GIE;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  twc_tmr u_setup (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .start(setup_go),
    .load(st_q.tim[SETUP_BIT] ? SETUP_EIGHT_CYC : SETUP_FOUR_CYC),
    .busy(CLIENT_SCL_STRETCH)
  );

  twc_tmr u_host_hold (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .start(run && scl_fall),
    .load(hold_cyc(st_q.cfg.host_hold)),
    .busy(HOST_SDA_HOLD)
  );

  twc_tmr u_client_hold (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .start(run && scl_fall),
    .load(hold_cyc(st_q.cfg.client_hold)),
    .busy(CLIENT_SDA_HOLD)
  );

  assign RDATA = st_q.rdata;
  assign CMD = st_q.cmd;
  assign CFG = st_q.cfg;
  assign BUS_STATE = st_q.bus;
  assign RD_IRQ = st_q.rirq;
  assign WR_IRQ = st_q.wirq;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  property p_rd_irq;
    (st_q.read_done_flag && st_q.hcta[READ_IRQ_ENABLE_BIT] && GIE) |=> RD_IRQ;
  endproperty
  a_rd_irq: assert property (p_rd_irq)
    else $error("read irq missing");

  property p_rd_irq_gate;
    !(st_q.hcta[READ_IRQ_ENABLE_BIT] && GIE) |=> !RD_IRQ;
  endproperty
  a_rd_irq_gate: assert property (p_rd_irq_gate)
    else $error("read irq without enables");

  property p_wr_irq;
    (st_q.write_done_flag && st_q.hcta[WRITE_IRQ_ENABLE_BIT] && GIE) |=> WR_IRQ;
  endproperty
  a_wr_irq: assert property (p_wr_irq)
    else $error("write irq missing");

  property p_halt_ignore;
    (DBG_HALT && !st_q.dbg[RUN_BIT])
      |=> (!$rose(st_q.read_done_flag) && !$rose(st_q.write_done_flag));
  endproperty
  a_halt_ignore: assert property (p_halt_ignore)
    else $error("event taken while halted");

  property p_run_data;
    (DBG_HALT && st_q.dbg[RUN_BIT] && RD && ADDR == OFS_HDATA && st_q.read_done_flag)
      |=> (st_q.read_done_flag && !CMD.smart_ack);
  endproperty
  a_run_data: assert property (p_run_data)
    else $error("data access acted while halted");

  property p_setup_long;
    (setup_go && st_q.tim[SETUP_BIT]) |=>
      CLIENT_SCL_STRETCH [*8] ##1 (!CLIENT_SCL_STRETCH || $past(setup_go));
  endproperty
  a_setup_long: assert property (p_setup_long)
    else $error("setup stretch not eight cycles");

  property p_client_cfg;
    !st_q.dual[DUAL_EN_BIT] |=>
      (CFG.client_hold == $past(st_q.tim[HOLD_LSB+:2])
       && CFG.client_fmp == $past(st_q.tim[FMP_BIT]));
  endproperty
  a_client_cfg: assert property (p_client_cfg)
    else $error("dual field used while dual off");

  property p_quick;
    (run && EV.addr_ack && EV.addr_dir && st_q.hcta[QUICK_COMMAND_ENABLE_BIT])
      |=> st_q.read_done_flag;
  endproperty
  a_quick: assert property (p_quick)
    else $error("quick read flag missing");

  property p_tout;
    tout_hit && st_q.hcta[HEN_BIT] && !st_q.cmd.flush && !start_c
      |=> BUS_STATE == BUS_IDLE ##1 st_q.tcnt == $past(lim, 2);
  endproperty
  a_tout: assert property (p_tout)
    else $error("time-out did not idle the bus");

  property p_host_off;
    !st_q.hcta[HEN_BIT] |=> (BUS_STATE == BUS_UNKNOWN && !CFG.host_en);
  endproperty
  a_host_off: assert property (p_host_off)
    else $error("disabled host shows bus state");

  c_quick: cover property (EV.addr_ack && st_q.hcta[QUICK_COMMAND_ENABLE_BIT] ##1 st_q.read_done_flag);
  c_tout: cover property (tout_hit);
  c_smart: cover property (CMD.smart_ack);
  c_halt_run: cover property (DBG_HALT && st_q.dbg[RUN_BIT] && WR
                              && ADDR == OFS_HDATA);
endmodule
`default_nettype wire

// File: verification/twc_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module twc_bus_model (
  // Bus lines, pulled up when released
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, a few bits at 160 ns, then SCL held low so the bus looks stuck
  task automatic start_stall(input int bits);
    #2 sda = 1'b0;
    #80 scl = 1'b0;
    for (int i = 0; i < bits; i++) begin
      sda = i[0];
      #80 scl = 1'b1;
      #80 scl = 1'b0;
    end
  endtask
  task automatic stop_cond();
    #2 sda = 1'b0;
    #80 scl = 1'b1;
    #80 sda = 1'b1;
  endtask
  // One SCL low phase with SDA left high, so no start or stop is seen
  task automatic scl_pulse();
    #2 scl = 1'b0;
    #80 scl = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verification/test_two_wire_config_and_debug.sv
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_config_and_debug;
  import twc_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic halt = 1'b0;
  logic gie = 1'b0;
  twc_ev_s ev = '0;
  twc_cmd_s cmd;
  twc_cfg_s cfg;
  logic [1:0] bus_state;
  logic [7:0] rdata;
  logic cst, rd_irq, wr_irq, rd_p;
  logic hh, ch;
  wire scl;
  wire sda;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int st_cnt = 0;
  int go_cnt = 0;
  int hh_cnt = 0;
  int ch_cnt = 0;
  integer seed = 32'hC5E1;
  logic [15:0] exp_q[$];
  logic [7:0] msk[4] = '{TIMING_MASK, DUAL_MASK, DBG_MASK, HCTLA_MASK};
  logic [7:0] hcy[4] = '{8'h00, HOLD_SHORT_CYC, HOLD_TYPICAL_CYC,
    HOLD_ALL_CYC};

  always #4 sys_clk = ~sys_clk;

  // Short time-out limits keep the stuck-bus runs brief
  twc_core #(.TOUT_SHORTEST_CYC(50), .TOUT_MIDDLE_CYC(100),
    .TOUT_LONGEST_CYC(200)) i_dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .DBG_HALT(halt), .GIE(gie),
    .SCL_PIN(scl), .SDA_PIN(sda), .EV(ev), .CMD(cmd), .CFG(cfg),
    .BUS_STATE(bus_state), .HOST_SDA_HOLD(hh), .CLIENT_SDA_HOLD(ch),
    .CLIENT_SCL_STRETCH(cst), .RD_IRQ(rd_irq), .WR_IRQ(wr_irq));
  twc_bus_model i_bus (.scl(scl), .sda(sda));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  // Expected byte and compare mask are queued for the read monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge sys_clk);
    rd_s <= 1'b0;
  endtask
  task automatic pulse(input twc_ev_s e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    logic [15:0] n;
    if (rd_p) begin
      n = exp_q.pop_front();
      cmp("read data", {8'h00, n[7:0] & n[15:8]}, {8'h00, rdata & n[15:8]});
    end
    rd_p <= rd_s;
    if (cst) st_cnt++;
    if (hh) hh_cnt++;
    if (ch) ch_cnt++;
    if (cmd.tx_go || cmd.smart_ack || cmd.cdata_go) go_cnt++;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    int n;
    int lim;
    logic [7:0] v;
    tick(16);
    rstn <= 1'b1;
    tick(2);
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      wr(4'(i % 4), v);
      rd(4'(i % 4), v & msk[i % 4], 8'hFF);
    end
    wr(4'hF, v);
    rd(4'hF, 8'h00, 8'hFF);
    for (int a = 0; a < 4; a++) wr(4'(a), 8'h00);
    for (int h = 0; h < 4; h++) begin
      wr(OFS_TIMING, 8'(h << HOLD_LSB) | 8'h02);
      wr(OFS_DUAL, 8'((3 - h) << HOLD_LSB));
      tick(3);
      cmp("cfg dual off", {9'h0, 2'(h), 2'(h), 3'b110}, {9'h0,
        cfg.host_hold, cfg.client_hold, cfg.host_fmp, cfg.client_fmp,
        cfg.dual_en});
      wr(OFS_DUAL, 8'((3 - h) << HOLD_LSB) | 8'h01);
      tick(3);
      cmp("cfg dual on", {9'h0, 2'(h), 2'(3 - h), 3'b101}, {9'h0,
        cfg.host_hold, cfg.client_hold, cfg.host_fmp, cfg.client_fmp,
        cfg.dual_en});
      hh_cnt = 0;
      ch_cnt = 0;
      i_bus.scl_pulse();
      tick(72);
      cmp("host hold", 16'(hcy[h]), 16'(hh_cnt));
      cmp("client hold", 16'(hcy[3 - h]), 16'(ch_cnt));
    end
    wr(OFS_DUAL, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_TIMING, 8'(s << SETUP_BIT));
      tick(3);
      st_cnt = 0;
      pulse(twc_ev_s'(5'h01));
      tick(12);
      cmp("setup stretch", 16'(s ? 8 : 4), 16'(st_cnt));
    end
    // Quick command with interrupts enabled, global enable still off
    wr(OFS_HCTLA, 8'hD3);
    pulse(twc_ev_s'(5'h18));
    tick(3);
    cmp("read irq without global", 16'h0, {15'h0, rd_irq});
    gie <= 1'b1;
    tick(3);
    cmp("read irq", 16'h1, {15'h0, rd_irq});
    cmp("write irq idle", 16'h0, {15'h0, wr_irq});
    rd(OFS_HSTAT, 8'h80, 8'hC0);
    wr(OFS_HCTLB, {6'h00, CMD_STOP});
    rd(OFS_HSTAT, 8'h00, 8'hC0);
    pulse(twc_ev_s'(5'h10));
    tick(3);
    cmp("write irq", 16'h1, {15'h0, wr_irq});
    wr(OFS_HCTLA, 8'h93);
    tick(3);
    cmp("write irq disabled", 16'h0, {15'h0, wr_irq});
    cmp("bus owner", {14'h0, BUS_OWNER}, {14'h0, bus_state});
    wr(OFS_HCTLB, 8'h08);
    tick(3);
    cmp("bus after flush", {14'h0, BUS_IDLE}, {14'h0, bus_state});
    // Halted without run: events dropped, flags kept
    halt <= 1'b1;
    pulse(twc_ev_s'(5'h18));
    tick(3);
    rd(OFS_HSTAT, 8'h40, 8'hC0);
    wr(OFS_DBG, 8'h01);
    pulse(twc_ev_s'(5'h18));
    go_cnt = 0;
    wr(OFS_HDATA, 8'h5A);
    rd(OFS_HDATA, 8'h5A, 8'hFF);
    wr(OFS_CDATA, 8'h3C);
    tick(2);
    rd(OFS_HSTAT, 8'hC0, 8'hC0);
    cmp("halted data side effects", 16'h0, 16'(go_cnt));
    halt <= 1'b0;
    rd(OFS_HDATA, 8'h5A, 8'hFF);
    tick(2);
    cmp("auto ack on data read", 16'h1, 16'(go_cnt));
    rd(OFS_HSTAT, 8'h00, 8'hC0);
    wr(OFS_HDATA, 8'hA5);
    tick(2);
    cmp("transmit on data write", 16'h2, 16'(go_cnt));
    wr(OFS_CDATA, 8'hC3);
    tick(2);
    cmp("client transmit", 16'h3, 16'(go_cnt));
    wr(OFS_DBG, 8'h00);
    // Stuck bus for each time-out code, then a stop frees it
    for (int c = 0; c < 4; c++) begin
      wr(OFS_HCTLA, 8'(c << TOUT_LSB) | 8'h01);
      i_bus.start_stall(3);
      tick(1);
      cmp("bus busy", {14'h0, BUS_BUSY}, {14'h0, bus_state});
      n = 0;
      while (bus_state !== BUS_IDLE && n < 300) begin
        tick(1);
        n++;
      end
      lim = (c == 0) ? 300 : 25 << c;
      cmp("time-out window", 16'h1,
        16'(n >= lim - 4 && n <= lim + 8));
      i_bus.stop_cond();
      tick(8);
      cmp("idle after stop", {14'h0, BUS_IDLE}, {14'h0, bus_state});
    end
    wr(OFS_HCTLA, 8'h00);
    tick(3);
    cmp("host disabled", {14'h0, BUS_UNKNOWN}, {14'h0, bus_state});
    tick(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
